// File: logic/bbe_pkg.sv
// Constants, opcodes and types for the branch and bit execution core.
// Assumes a combinational program memory and one 10 MHz core clock.
// Summary of operation
// - Table read via data pointer loads accumulator from program memory at A plus pointer.
// - Table read via program counter loads accumulator from program memory at A plus PC.
// - PC base already points past the table read, so index zero hits next opcode.
// - Table reads only read program memory; the core has no program memory write path.
// - Bit addresses below 80H are RAM bits; 80H and above are special register bits.
// - Every port line is a separately readable, settable and clearable bit.
// - Bit operands come only from a direct bit address inside the instruction.
// - Carry in the status word is the bit accumulator and has its own bit address.
// - Move carry to or from any bit; set, clear, complement carry or any bit.
// - AND or OR carry with a bit or its inverse into carry; no bit XOR.
// - Bit tests branch when carry or bit is one, or zero for inverted forms.
// - Jump on set and clear branches on a one bit and clears it atomically.
// - Taken relative branch adds signed offset to address after the instruction.
// - Short relative jump is two bytes: opcode and offset.
// - Long jump is three bytes carrying a full 16-bit destination.
// - Page jump is two bytes; opcode holds 3 address bits, second byte low 8.
// - Page jump replaces low 11 PC bits; upper 5 after stepping are kept.
// - Indirect jump loads PC with data pointer plus accumulator at execution.
// - Long call carries a 16-bit subroutine address anywhere in program memory.
// - Page call carries 11 bits and stays in the block of the next instruction.
// - Interrupt return acts as return and tells the interrupt controller it finished.
package bbe_pkg;
  localparam int PC_W = 16;
  localparam int RAM_AW = 4;
  localparam int STK_AW = 3;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_JBC = 8'h10;
  localparam logic [7:0] OP_JB = 8'h20;
  localparam logic [7:0] OP_JNB = 8'h30;
  localparam logic [7:0] OP_RET = 8'h22;
  localparam logic [7:0] OP_INTERRUPT_RETURN = 8'h32;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_ORL_C_BIT = 8'h72;
  localparam logic [7:0] OP_JMP_IND = 8'h73;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h74;
  localparam logic [7:0] OP_SHORT_RELATIVE_JUMP = 8'h80;
  localparam logic [7:0] OP_ANL_C_BIT = 8'h82;
  localparam logic [7:0] OP_CONST_TABLE_READ_PC = 8'h83;
  localparam logic [7:0] OP_MOV_DATA_POINTER = 8'h90;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  localparam logic [7:0] OP_CONST_TABLE_READ_DATA_POINTER = 8'h93;
  localparam logic [7:0] OP_ORL_C_NBIT = 8'hA0;
  localparam logic [7:0] OP_MOV_C_BIT = 8'hA2;
  localparam logic [7:0] OP_ANL_C_NBIT = 8'hB0;
  localparam logic [7:0] OP_CPL_BIT = 8'hB2;
  localparam logic [7:0] OP_CPL_C = 8'hB3;
  localparam logic [7:0] OP_CLR_BIT = 8'hC2;
  localparam logic [7:0] OP_CLR_C = 8'hC3;
  localparam logic [7:0] OP_BIT_SET_OP_BIT = 8'hD2;
  localparam logic [7:0] OP_BIT_SET_OP_C = 8'hD3;
  localparam logic [4:0] OP_PAGE_ABSOLUTE_JUMP_LO = 5'h01;
  localparam logic [4:0] OP_PAGE_ABSOLUTE_CALL_LO = 5'h11;
  localparam logic [7:0] SFR_PORT0 = 8'h80;
  localparam logic [7:0] SFR_PORT1 = 8'h90;
  localparam logic [7:0] SFR_PORT2 = 8'hA0;
  localparam logic [7:0] SFR_PORT3 = 8'hB0;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] SFR_ACC = 8'hE0;
  localparam int CARRY_POS = 7;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] DATA_POINTER_RST = 16'h0000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [2:0] SP_RST = 3'h0;
  localparam logic [31:0] PORT_RST = 32'hFFFFFFFF;

  typedef enum logic [2:0]
  {
    ST_FETCH = 3'b000,
    ST_OPND1 = 3'b001,
    ST_OPND2 = 3'b010,
    ST_READ = 3'b011,
    ST_EXEC = 3'b100
  } bbe_state_t;

  typedef struct packed
  {
    logic [15:0] pc;
    logic [15:0] data_pointer;
    logic [7:0] acc;
    logic [7:0] program_status_word;
    logic [2:0] sp;
  } bbe_core_state_t;

  // Byte count of an opcode; unknown opcodes run as one-byte no-ops
  function automatic logic [1:0] bbe_instr_len(input logic [7:0] op);
    logic [1:0] len;
    len = 2'd1;
    if (op == OP_LONG_JUMP || op == OP_LONG_CALL || op == OP_MOV_DATA_POINTER || op == OP_JB || op == OP_JNB || op == OP_JBC)
    begin
      len = 2'd3;
    end
    else if (op[4:0] == OP_PAGE_ABSOLUTE_JUMP_LO || op[4:0] == OP_PAGE_ABSOLUTE_CALL_LO || op == OP_SHORT_RELATIVE_JUMP || op == OP_JC
             || op == OP_JNC || op == OP_MOV_A_IMM || op == OP_ANL_C_BIT || op == OP_ANL_C_NBIT
             || op == OP_ORL_C_BIT || op == OP_ORL_C_NBIT || op == OP_MOV_C_BIT || op == OP_MOV_BIT_C
             || op == OP_CLR_BIT || op == OP_BIT_SET_OP_BIT || op == OP_CPL_BIT)
    begin
      len = 2'd2;
    end
    return len;
  endfunction
endpackage

// File: logic/bbe_mem.sv
// Small synchronous memory with registered read data.
// Assumes one clock; write and read may hit the same word, read sees old data.
module bbe_mem #(
  parameter int AW = 4,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read side
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem_ff [2**AW];

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= mem_ff[rd_addr];
    end
  end
endmodule

// File: logic/bbe_core.sv
// Branch, table read and single-bit execution core.
// Assumes program memory answers pmem_addr in the same cycle.
module bbe_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Program memory
  output logic [15:0] pmem_addr,
  input wire logic [7:0] pmem_rdata,
  // Port lines
  input wire logic [31:0] port_pins,
  output logic [31:0] port_latch,
  // Interrupt controller
  output logic int_done,
  // Observation
  output bbe_pkg::bbe_core_state_t core_state
);
  import bbe_pkg::*;

  logic [1:0] rst_sync_ff;
  logic rst_n;
  bbe_state_t st_ff;
  logic [7:0] op_ff;
  logic [7:0] opnd1_ff;
  logic [7:0] opnd2_ff;
  logic [15:0] pc_ff;
  logic [15:0] data_pointer_ff;
  logic [7:0] acc_ff;
  logic [7:0] psw_ff;
  logic [2:0] sp_ff;
  logic [31:0] port_ff;
  logic exec;
  logic [7:0] bit_addr;
  logic [7:0] ram_rdata;
  logic [7:0] rd_byte;
  logic [7:0] wr_base;
  logic [7:0] wbyte;
  logic bit_val;
  logic bit_wr;
  logic bit_new;
  logic nxt_carry;
  logic take;
  logic [7:0] rel;
  logic [15:0] rel_ext;
  logic [15:0] stk_rdata;
  logic is_page_absolute_jump;
  logic is_page_absolute_call;
  logic is_call;
  logic is_ret;
  logic ram_we;
  logic stk_we;
  logic [2:0] stk_rd_addr;

  // Special register byte as seen for a bit access
  function automatic logic [7:0] sfr_byte(input logic [7:0] ba, input logic [31:0] ports,
                                         input logic [7:0] program_status_word, input logic [7:0] acc);
    logic [7:0] b;
    b = 8'h00;
    case ({ba[7:3], 3'b000})
      SFR_PORT0: b = ports[7:0];
      SFR_PORT1: b = ports[15:8];
      SFR_PORT2: b = ports[23:16];
      SFR_PORT3: b = ports[31:24];
      SFR_PSW: b = program_status_word;
      SFR_ACC: b = acc;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_sync_ff <= 2'b00;
    end
    else
    begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  assign exec = (st_ff == ST_EXEC);
  assign is_page_absolute_jump = (op_ff[4:0] == OP_PAGE_ABSOLUTE_JUMP_LO);
  assign is_page_absolute_call = (op_ff[4:0] == OP_PAGE_ABSOLUTE_CALL_LO);
  assign is_call = is_page_absolute_call || (op_ff == OP_LONG_CALL);
  assign is_ret = (op_ff == OP_RET) || (op_ff == OP_INTERRUPT_RETURN);

  assign bit_addr = opnd1_ff;
  assign rd_byte = bit_addr[7] ? sfr_byte(bit_addr, port_pins, psw_ff, acc_ff) : ram_rdata;
  // ports written from latches, so pin loading cannot flip other lines
  assign wr_base = bit_addr[7] ? sfr_byte(bit_addr, port_ff, psw_ff, acc_ff) : ram_rdata;
  assign bit_val = rd_byte[bit_addr[2:0]];

  always_comb
  begin
    wbyte = wr_base;
    wbyte[bit_addr[2:0]] = bit_new;
  end

  // offset is byte 3 for bit tests
  assign rel = (op_ff == OP_JB || op_ff == OP_JNB || op_ff == OP_JBC) ? opnd2_ff : opnd1_ff;
  assign rel_ext = {{8{rel[7]}}, rel};

  always_comb
  begin
    nxt_carry = psw_ff[CARRY_POS];
    bit_wr = 1'b0;
    bit_new = bit_val;
    take = 1'b0;
    case (op_ff)
      // carry and bit set, clear, move
      OP_CLR_C: nxt_carry = 1'b0;
      OP_BIT_SET_OP_C: nxt_carry = 1'b1;
      OP_CPL_C: nxt_carry = ~psw_ff[CARRY_POS];
      OP_MOV_C_BIT: nxt_carry = bit_val;
      OP_ANL_C_BIT: nxt_carry = psw_ff[CARRY_POS] & bit_val;
      OP_ANL_C_NBIT: nxt_carry = psw_ff[CARRY_POS] & ~bit_val;
      OP_ORL_C_BIT: nxt_carry = psw_ff[CARRY_POS] | bit_val;
      OP_ORL_C_NBIT: nxt_carry = psw_ff[CARRY_POS] | ~bit_val;
      OP_MOV_BIT_C:
      begin
        bit_wr = 1'b1;
        bit_new = psw_ff[CARRY_POS];
      end
      OP_CLR_BIT:
      begin
        bit_wr = 1'b1;
        bit_new = 1'b0;
      end
      OP_BIT_SET_OP_BIT:
      begin
        bit_wr = 1'b1;
        bit_new = 1'b1;
      end
      OP_CPL_BIT:
      begin
        bit_wr = 1'b1;
        bit_new = ~bit_val;
      end
      // branch on carry or bit level
      OP_JC: take = psw_ff[CARRY_POS];
      OP_JNC: take = ~psw_ff[CARRY_POS];
      OP_JB: take = bit_val;
      OP_JNB: take = ~bit_val;
      // test and clear in one step
      OP_JBC:
      begin
        take = bit_val;
        bit_wr = bit_val;
        bit_new = 1'b0;
      end
      OP_SHORT_RELATIVE_JUMP: take = 1'b1;
      default: take = 1'b0;
    endcase
  end

  // address only, no write path to program memory
  always_comb
  begin
    pmem_addr = pc_ff;
    if (exec && op_ff == OP_CONST_TABLE_READ_DATA_POINTER)
    begin
      pmem_addr = 16'(data_pointer_ff + {8'h00, acc_ff});
    end
    else if (exec && op_ff == OP_CONST_TABLE_READ_PC)
    begin
      pmem_addr = 16'(pc_ff + {8'h00, acc_ff});
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= ST_FETCH;
    end
    else
    begin
      case (st_ff)
        ST_FETCH: st_ff <= (bbe_instr_len(pmem_rdata) == 2'd1) ? ST_READ : ST_OPND1;
        ST_OPND1: st_ff <= (bbe_instr_len(op_ff) == 2'd3) ? ST_OPND2 : ST_READ;
        ST_OPND2: st_ff <= ST_READ;
        ST_READ: st_ff <= ST_EXEC;
        ST_EXEC: st_ff <= ST_FETCH;
        default: st_ff <= ST_FETCH;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_ff <= OP_NOP;
      opnd1_ff <= 8'h00;
      opnd2_ff <= 8'h00;
    end
    else if (st_ff == ST_FETCH)
    begin
      op_ff <= pmem_rdata;
    end
    else if (st_ff == ST_OPND1)
    begin
      opnd1_ff <= pmem_rdata;
    end
    else if (st_ff == ST_OPND2)
    begin
      opnd2_ff <= pmem_rdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_ff <= PC_RST;
    end
    else if (st_ff == ST_FETCH || st_ff == ST_OPND1 || st_ff == ST_OPND2)
    begin
      pc_ff <= 16'(pc_ff + 16'h0001);
    end
    else if (exec)
    begin
      if (op_ff == OP_LONG_JUMP || op_ff == OP_LONG_CALL)
      begin
        pc_ff <= {opnd1_ff, opnd2_ff};
      end
      else if (is_page_absolute_jump || is_page_absolute_call)
      begin
        pc_ff <= {pc_ff[15:11], op_ff[7:5], opnd1_ff};
      end
      else if (op_ff == OP_JMP_IND)
      begin
        pc_ff <= 16'(data_pointer_ff + {8'h00, acc_ff});
      end
      else if (is_ret)
      begin
        pc_ff <= stk_rdata;
      end
      else if (take)
      begin
        pc_ff <= 16'(pc_ff + rel_ext);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_ff <= ACC_RST;
    end
    else if (exec && (op_ff == OP_CONST_TABLE_READ_DATA_POINTER || op_ff == OP_CONST_TABLE_READ_PC))
    begin
      acc_ff <= pmem_rdata;
    end
    else if (exec && op_ff == OP_MOV_A_IMM)
    begin
      acc_ff <= opnd1_ff;
    end
    else if (exec && bit_wr && {bit_addr[7:3], 3'b000} == SFR_ACC)
    begin
      acc_ff <= wbyte;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_pointer_ff <= DATA_POINTER_RST;
    end
    else if (exec && op_ff == OP_MOV_DATA_POINTER)
    begin
      data_pointer_ff <= {opnd1_ff, opnd2_ff};
    end
  end

  // carry lives in status word, also bit-addressable
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      psw_ff <= PSW_RST;
    end
    else if (exec && bit_wr && {bit_addr[7:3], 3'b000} == SFR_PSW)
    begin
      psw_ff <= wbyte;
    end
    else if (exec)
    begin
      psw_ff[CARRY_POS] <= nxt_carry;
    end
  end

  // one latch bit per port line
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_ff <= PORT_RST;
    end
    else if (exec && bit_wr && bit_addr[7:6] == 2'b10 && !bit_addr[3])
    begin
      port_ff[{bit_addr[5:4], 3'b000} +: 8] <= wbyte;
    end
  end

  // Stack wraps at eight levels; deeper nesting overwrites the oldest entry
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sp_ff <= SP_RST;
    end
    else if (exec && is_call)
    begin
      sp_ff <= 3'(sp_ff + 3'h1);
    end
    else if (exec && is_ret)
    begin
      sp_ff <= 3'(sp_ff - 3'h1);
    end
  end

  assign ram_we = exec && bit_wr && !bit_addr[7];
  assign stk_we = exec && is_call;
  assign stk_rd_addr = 3'(sp_ff - 3'h1);

  bbe_mem #(.AW(RAM_AW), .DW(8)) u_bit_ram (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(ram_we),
    .wr_addr(bit_addr[6:3]),
    .wr_data(wbyte),
    .rd_addr(bit_addr[6:3]),
    .rd_data(ram_rdata)
  );

  bbe_mem #(.AW(STK_AW), .DW(PC_W)) u_stack (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(stk_we),
    .wr_addr(sp_ff),
    .wr_data(pc_ff),
    .rd_addr(stk_rd_addr),
    .rd_data(stk_rdata)
  );

  assign int_done = exec && (op_ff == OP_INTERRUPT_RETURN);
  assign port_latch = port_ff;
  assign core_state = '{pc: pc_ff, data_pointer: data_pointer_ff, acc: acc_ff, program_status_word: psw_ff, sp: sp_ff};

  nop_holds_a:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (exec && op_ff == OP_NOP) |=> pc_ff == $past(pc_ff) && acc_ff == $past(acc_ff)
        && psw_ff == $past(psw_ff) && port_ff == $past(port_ff))
    else $error("no-operation changed state");
  short_relative_jump_target_a:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (exec && op_ff == OP_SHORT_RELATIVE_JUMP) |=> pc_ff == 16'($past(pc_ff) + $past(rel_ext)))
    else $error("relative jump target wrong");
  long_jump_target_a:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_ff == ST_OPND2 && op_ff == OP_LONG_JUMP) |-> ##3 pc_ff == {opnd1_ff, opnd2_ff})
    else $error("long jump target wrong");
  page_absolute_jump_page_a:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (exec && is_page_absolute_jump) |=> pc_ff[15:11] == $past(pc_ff[15:11]) && pc_ff[7:0] == $past(opnd1_ff))
    else $error("page jump left its block");
  ind_jump_a:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (exec && op_ff == OP_JMP_IND) |=> pc_ff == 16'($past(data_pointer_ff) + {8'h00, $past(acc_ff)}))
    else $error("indirect jump target wrong");
  const_table_read_load_a:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (exec && op_ff == OP_CONST_TABLE_READ_DATA_POINTER) |=> acc_ff == $past(pmem_rdata) && st_ff == ST_FETCH)
    else $error("table read did not load accumulator");
  const_table_read_base_a:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_ff == ST_FETCH && pmem_rdata == OP_CONST_TABLE_READ_PC) |-> ##2 pmem_addr == 16'($past(pc_ff, 2)
        + 16'h0001 + {8'h00, acc_ff}))
    else $error("table read base not next opcode");
  jbc_clear_a:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (exec && op_ff == OP_JBC) |-> take == bit_val && bit_wr == bit_val && !bit_new)
    else $error("jump set and clear did not clear");
  anl_carry_a:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (exec && op_ff == OP_ANL_C_NBIT) |=> psw_ff[CARRY_POS] == ($past(psw_ff[CARRY_POS]) & ~$past(bit_val)))
    else $error("carry AND result wrong");
  call_push_a:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (exec && is_call) |-> stk_we ##1 sp_ff == 3'($past(sp_ff) + 3'h1))
    else $error("call did not push");
  // completion strobe only on interrupt return
  interrupt_return_done_a:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      int_done |-> exec && op_ff == OP_INTERRUPT_RETURN ##1 st_ff == ST_FETCH)
    else $error("stray interrupt completion");
endmodule

// File: tb/bbe_prog_rom.sv
// Program memory model for the core: a read-only byte array.
// Assumes the bench loads the mem array while the core is held in reset.
module bbe_prog_rom (
  // Core side
  input wire logic [15:0] addr,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  // no write path
  // Answers in the same cycle, as the core samples it there
  assign rdata = mem[addr];
endmodule

// File: tb/branch_and_bit_execution_test.sv
// Self-checking bench for the branch and bit execution core.
// Assumes the program memory model above and a 10 MHz core clock.
module branch_and_bit_execution_test;
  timeunit 1ns;
  timeprecision 1ns;
  import bbe_pkg::*;
  logic core_clk;
  logic reset_n;
  logic [15:0] pmem_addr;
  logic [7:0] pmem_rdata;
  logic [31:0] port_pins;
  logic [31:0] port_latch;
  logic int_done;
  bbe_core_state_t core_state;
  logic [7:0] img [0:65535];
  logic [15:0] ptr;
  int fail_count;
  int n_compared;
  int n_done = 0;
  int done_base;
  logic [7:0] bops [4] = '{OP_ANL_C_BIT, OP_ANL_C_NBIT, OP_ORL_C_BIT, OP_ORL_C_NBIT};

  bbe_core dut (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pmem_addr(pmem_addr),
    .pmem_rdata(pmem_rdata),
    .port_pins(port_pins),
    .port_latch(port_latch),
    .int_done(int_done),
    .core_state(core_state)
  );

  bbe_prog_rom rom (
    .addr(pmem_addr),
    .rdata(pmem_rdata)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    if (int_done === 1'b1)
      n_done++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Compared %0d values, %0d mismatches", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic put(input logic [15:0] a, input logic [7:0] b);
    img[a] = b;
    rom.mem[a] = b;
  endtask

  task automatic e(input logic [7:0] b);
    put(ptr, b);
    ptr++;
  endtask

  task automatic e2(input logic [7:0] op, input logic [7:0] b);
    e(op);
    e(b);
  endtask

  task automatic halt_here(output logic [15:0] h);
    h = ptr;
    e2(OP_SHORT_RELATIVE_JUMP, 8'hFE);
  endtask

  // Core held in reset while a fresh program image is written
  task automatic start();
    @(negedge core_clk);
    reset_n = 1'b0;
    port_pins = $urandom;
    // Completion pulses counted from here; the counter has one driver
    done_base = n_done;
    for (int i = 0; i < 65536; i++)
      put(16'(i), OP_NOP);
    ptr = 16'h0000;
  endtask

  task automatic run(input logic [15:0] halt);
    int n;
    @(negedge core_clk);
    chk({port_latch[15:0], core_state.pc}, {PORT_RST[15:0], PC_RST}, "reset values");
    @(negedge core_clk);
    reset_n = 1'b1;
    n = 0;
    while (core_state.pc !== halt && n < 3000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 3000)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: program never reached its halt loop", $time);
      wrap_up();
    end
    // Halt loop is four cycles, so the last instruction has retired
    repeat (4) @(negedge core_clk);
  endtask

  function automatic logic [31:0] bit_latch(input logic a, input logic b, input logic c, input logic pin);
    logic [31:0] v;
    v = PORT_RST;
    v[3:0] = {a | ~b, a | b, a & ~b, a & b};
    v[7:4] = {1'b0, 1'b1, 1'b0, pin};
    v[19:16] = {a, ~a, ~c, c};
    return v;
  endfunction

  initial
  begin
    logic [7:0] r;
    logic [7:0] lo;
    logic [15:0] h;
    logic [15:0] t;
    logic a;
    logic b;
    logic c;
    logic [2:0] j;
    reset_n = 1'b0;
    port_pins = 32'h00000000;
    fail_count = 0;
    n_compared = 0;
    done_base = 0;
    ptr = 16'h0000;
    void'($urandom(58));
    for (int i = 0; i < 4; i++)
    begin
      r = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      t = {4'h3, 12'($urandom)};
      start();
      e2(OP_MOV_A_IMM, r);
      e(OP_NOP);
      e(OP_CONST_TABLE_READ_PC);
      halt_here(h);
      if (r > 8'h01)
        put(h + 16'(r), 8'($urandom));
      run(h);
      chk(32'(core_state.acc), 32'(img[h + 16'(r)]), "pc based table");
      start();
      e2(OP_MOV_DATA_POINTER, t[15:8]);
      e(t[7:0]);
      e2(OP_MOV_A_IMM, r);
      e(OP_CONST_TABLE_READ_DATA_POINTER);
      halt_here(h);
      put(t + 16'(r), 8'($urandom));
      run(h);
      chk(32'(core_state.acc), 32'(img[t + 16'(r)]), "pointer based table");
    end
    $display("Table read test done");
    for (int i = 0; i < 3; i++)
    begin
      {a, b, c} = 3'($urandom);
      j = 3'($urandom);
      start();
      e2(a ? OP_BIT_SET_OP_BIT : OP_CLR_BIT, 8'h05);
      e2(b ? OP_BIT_SET_OP_BIT : OP_CLR_BIT, 8'h7F);
      for (int k = 0; k < 4; k++)
      begin
        e2(OP_MOV_C_BIT, 8'h05);
        e2(bops[k], 8'h7F);
        e2(OP_MOV_BIT_C, 8'h80 + 8'(k));
      end
      e2(OP_MOV_C_BIT, {5'b10010, j});
      e2(OP_MOV_BIT_C, 8'h84);
      e(OP_BIT_SET_OP_C);
      e2(OP_CLR_BIT, 8'hD7);
      e2(OP_MOV_BIT_C, 8'h85);
      e2(OP_CPL_BIT, 8'h05);
      e2(OP_BIT_SET_OP_BIT, 8'h06);
      e2(OP_JBC, 8'h06);
      e2(8'h02, OP_CLR_BIT);
      e(8'h86);
      e2(OP_MOV_C_BIT, 8'h06);
      e2(OP_MOV_BIT_C, 8'h87);
      e(c ? OP_BIT_SET_OP_C : OP_CLR_C);
      e2(OP_JC, 8'h02);
      e2(OP_CLR_BIT, 8'hA0);
      e2(OP_JNC, 8'h02);
      e2(OP_CLR_BIT, 8'hA1);
      e2(OP_JB, 8'h05);
      e2(8'h02, OP_CLR_BIT);
      e(8'hA2);
      e2(OP_JNB, 8'h05);
      e2(8'h02, OP_CLR_BIT);
      e(8'hA3);
      e(OP_CPL_C);
      halt_here(h);
      run(h);
      chk(port_latch, bit_latch(a, b, c, port_pins[8 + j]), "bit results");
      chk(32'(core_state.program_status_word), {24'h000000, ~c, 7'h00}, "carry");
    end
    $display("Bit processor test done");
    for (int i = 0; i < 3; i++)
    begin
      r = (i == 0) ? 8'hFF : 8'($urandom);
      lo = 8'($urandom);
      t = 16'h4000 + 16'($urandom % 256);
      start();
      e2(OP_LONG_JUMP, t[15:8]);
      e(t[7:0]);
      ptr = t;
      e2(OP_LONG_CALL, 8'h80);
      e(8'h00);
      put(16'h8000, OP_RET);
      e2({3'b110, OP_PAGE_ABSOLUTE_CALL_LO}, lo);
      put({8'h46, lo}, OP_INTERRUPT_RETURN);
      e2({3'b111, OP_PAGE_ABSOLUTE_JUMP_LO}, lo);
      ptr = {8'h47, lo};
      e2(OP_MOV_DATA_POINTER, 8'h50);
      e(8'h00);
      e2(OP_MOV_A_IMM, r);
      e(OP_JMP_IND);
      ptr = 16'h5000 + 16'(r);
      e2(OP_SHORT_RELATIVE_JUMP, 8'h80);
      ptr = 16'h4F82 + 16'(r);
      e2(OP_SHORT_RELATIVE_JUMP, 8'h7F);
      ptr = 16'h5003 + 16'(r);
      halt_here(h);
      run(h);
      chk(32'(n_done - done_base), 32'd1, "interrupt return pulses");
      chk(32'(core_state.sp), 32'(SP_RST), "stack balanced");
      chk({core_state.data_pointer, 8'h00, core_state.acc}, {16'h5000, 8'h00, r}, "indirect jump operands");
    end
    $display("Jump chain test done");
    wrap_up();
  end
endmodule
